// ===== bench/vmc_host_model.sv
// Host side model: clock line frames and the register port of the serial engine.
`timescale 1ns/10ps
module vmc_host_model (
  input  wire logic       clk,
  output logic            scl_pin,
  output logic            reg_wr_en,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wr_data,
  input  wire logic [7:0] reg_rd_data
);
  // The line idles high through its pull-up.
  initial begin
    scl_pin = 1'b1;
    reg_wr_en = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
  end
  // Nine bit clocks at 800 ns, every edge on a falling core clock edge.
  task automatic frame();
    for (int i = 0; i < 9; i++) begin
      repeat (4) @(negedge clk);
      scl_pin = 1'b0;
      repeat (4) @(negedge clk);
      scl_pin = 1'b1;
    end
  endtask : frame
  // One byte write; no frame while the line is held low, so shutdown is kept.
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    if (scl_pin) begin
      frame();
    end
    @(negedge clk);
    reg_addr = addr;
    reg_wr_data = data;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
    reg_wr_data = ~data;
  endtask : wr
  // One byte read, taken two full cycles after the address is set.
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    frame();
    @(negedge clk);
    reg_addr = addr;
    @(negedge clk);
    @(negedge clk);
    data = reg_rd_data;
  endtask : rd
  // Holds the clock line at a level from the next falling edge.
  task automatic set_scl(input logic level);
    @(negedge clk);
    scl_pin = level;
  endtask : set_scl
endmodule : vmc_host_model

// ===== bench/vmc_mode_controller_test.sv
// Self-checking bench for the coil driver mode controller.
`timescale 1ns/10ps
module vmc_mode_controller_test;
  logic clk = 1'b0;  // Core clock, 100 ns period.
  logic arst_n = 1'b0;  // Reset, active low.
  logic scl_pin, reg_wr_en;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, freq_code, freq_hz;
  logic [2:0] fault_in = 3'h0;  // Fault levels {open, short, overtemp}.
  logic [1:0] op_mode;
  logic drive_enable, ring_comp_enable, pwm_mode;
  logic [9:0] coil_current;
  logic [2:0] fault_status;
  logic [7:0] rd_val;  // Last byte read back.
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  vmc_host_model vmc_host_model_inst (.clk(clk), .scl_pin(scl_pin), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data));
  vmc_mode_controller #(.SCL_LOW_CYC(20)) vmc_mode_controller_inst (.clk(clk), .arst_n(arst_n),
    .scl_pin(scl_pin), .over_temp_fault(fault_in[0]), .coil_short_fault(fault_in[1]),
    .coil_open_fault(fault_in[2]), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .op_mode(op_mode),
    .drive_enable(drive_enable), .coil_current_setting(coil_current),
    .resonance_frequency_code(freq_code), .resonance_hz(freq_hz),
    .ring_comp_enable(ring_comp_enable), .pwm_mode(pwm_mode), .fault_status(fault_status));
  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // A hang counts as a mismatch and still ends in the report.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Waits a bounded number of cycles for a mode, then compares it.
  task automatic wait_mode(input logic [1:0] mode, input int limit);
    for (int n = 0; n < limit && op_mode !== mode; n++) begin
      @(negedge clk);
    end
    check("op_mode", 10'(mode), 10'(op_mode));
  endtask : wait_mode
  task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
    vmc_host_model_inst.rd(addr, rd_val);
    check("reg_rd_data", 10'(exp), 10'(rd_val));
  endtask : rd_check
  // Wake from shutdown loads the frequency, control and status defaults; unmapped place reads zero.
  task automatic t_wake();
    wait_mode(2'h1, 10);
    rd_check(8'h07, 8'h83);
    rd_check(8'h02, 8'h02);
    rd_check(8'h05, 8'h00);
    rd_check(8'h01, 8'h00);
  endtask : t_wake
  // Table ends, a step boundary and a code between steps.
  task automatic t_freq();
    logic [7:0] codes [6] = '{8'h00, 8'h07, 8'h06, 8'h82, 8'hFB, 8'hFF};
    logic [7:0] hz [6] = '{8'h32, 8'h33, 8'h32, 8'h4C, 8'h92, 8'h96};
    for (int i = 0; i < 6; i++) begin
      vmc_host_model_inst.wr(8'h07, codes[i]);
      @(negedge clk);
      check("resonance_hz", 10'(hz[i]), 10'(freq_hz));
    end
  endtask : t_freq
  // Nonzero current starts the stage; zero in both bytes stops it.
  task automatic t_active();
    vmc_host_model_inst.wr(8'h07, 8'h83);
    vmc_host_model_inst.wr(8'h03, 8'h40);
    wait_mode(2'h2, 4);
    vmc_host_model_inst.wr(8'h04, 8'h03);
    check("coil_current", 10'h103, coil_current);
    check("drive_enable", 10'h001, 10'(drive_enable));
    vmc_host_model_inst.wr(8'h03, 8'h00);
    vmc_host_model_inst.wr(8'h04, 8'h00);
    wait_mode(2'h1, 4);
  endtask : t_active
  // Each fault drops to standby; the next entry clears the flags.
  task automatic t_fault();
    for (int i = 0; i < 3; i++) begin
      vmc_host_model_inst.wr(8'h03, 8'h11);
      wait_mode(2'h2, 4);
      check("fault_status", 10'h000, 10'(fault_status));
      @(negedge clk);
      fault_in = 3'(1 << i);
      wait_mode(2'h1, 6);
      check("coil_current", 10'h000, coil_current);
      check("fault_status", 10'(1 << i), 10'(fault_status));
      fault_in = 3'h0;
      vmc_host_model_inst.wr(8'h05, 8'h00);
      rd_check(8'h05, 8'(1 << i));
    end
  endtask : t_fault
  // Soft reset in active: standby, defaults, bit reads back zero.
  task automatic t_soft();
    vmc_host_model_inst.wr(8'h07, 8'h20);
    vmc_host_model_inst.wr(8'h06, 8'h01);
    vmc_host_model_inst.wr(8'h02, 8'h00);
    check("pwm_mode", 10'h001, 10'(pwm_mode));
    check("ring_comp_enable", 10'h000, 10'(ring_comp_enable));
    vmc_host_model_inst.wr(8'h03, 8'h08);
    wait_mode(2'h2, 4);
    vmc_host_model_inst.wr(8'h02, 8'h03);
    check("op_mode", 10'h001, 10'(op_mode));
    check("freq_code", 10'h083, 10'(freq_code));
    check("pwm_mode", 10'h000, 10'(pwm_mode));
    check("ring_comp_enable", 10'h001, 10'(ring_comp_enable));
    rd_check(8'h02, 8'h02);
  endtask : t_soft
  // A short low pulse is ignored; a long one shuts down until the line rises.
  task automatic t_shutdown();
    vmc_host_model_inst.wr(8'h03, 8'h01);
    wait_mode(2'h2, 4);
    vmc_host_model_inst.set_scl(1'b0);
    repeat (12) @(negedge clk);
    vmc_host_model_inst.set_scl(1'b1);
    repeat (4) @(negedge clk);
    check("op_mode", 10'h002, 10'(op_mode));
    vmc_host_model_inst.set_scl(1'b0);
    wait_mode(2'h0, 30);
    vmc_host_model_inst.wr(8'h03, 8'h20);
    repeat (8) @(negedge clk);
    check("op_mode", 10'h000, 10'(op_mode));
    vmc_host_model_inst.set_scl(1'b1);
    wait_mode(2'h1, 8);
    check("coil_current", 10'h000, coil_current);
  endtask : t_shutdown
  initial begin
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    t_wake();
    t_freq();
    t_active();
    t_fault();
    t_soft();
    t_shutdown();
    print_verdict();
  end
endmodule : vmc_mode_controller_test

// ===== bench/vmc_mode_monitor.sv
// Concurrent checks on the ports of the coil driver mode controller.
`timescale 1ns/10ps
module vmc_mode_monitor #(
  parameter int SCL_LOW_CYC = 5000  // Low time before shutdown.
) (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       scl_pin,
  input wire logic       over_temp_fault,
  input wire logic       coil_short_fault,
  input wire logic       coil_open_fault,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic [1:0] op_mode,
  input wire logic       drive_enable,
  input wire logic [9:0] coil_current_setting,
  input wire logic [7:0] resonance_frequency_code,
  input wire logic [7:0] resonance_hz,
  input wire logic       ring_comp_enable,
  input wire logic [2:0] fault_status
);
  logic [15:0] low_cnt_r;  // Cycles the clock line has stayed low.
  logic        fault_any;  // Any protection fault level high.
  assign fault_any = over_temp_fault | coil_short_fault | coil_open_fault;
  // Saturating count, so a long shutdown never wraps back to a short one.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt_r <= 16'h0000;
    end else if (scl_pin) begin
      low_cnt_r <= 16'h0000;
    end else if (low_cnt_r != 16'hFFFF) begin
      low_cnt_r <= low_cnt_r + 16'h0001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // A nonzero current byte taken in standby with no fault pending.
  sequence cur_write_s;
    reg_wr_en && reg_addr == 8'h03 && reg_wr_data != 8'h00 && op_mode == 2'h1 && !fault_any;
  endsequence
  // A soft reset request taken while the output stage runs.
  sequence soft_rst_s;
    reg_wr_en && reg_addr == 8'h02 && reg_wr_data[0] && op_mode == 2'h2;
  endsequence
  chk_drive_follows_mode: assert property (drive_enable == (op_mode == 2'h2))
    else $error("drive enable differs from active mode");
  chk_active_needs_current: assert property (op_mode == 2'h2 |-> coil_current_setting != 10'h000)
    else $error("active mode with zero current");
  chk_write_goes_active: assert property (cur_write_s |-> ##2 op_mode == 2'h2)
    else $error("nonzero current did not start active mode");
  chk_fault_drops_active: assert property (op_mode == 2'h2 && fault_any |-> ##[1:4] op_mode == 2'h1)
    else $error("fault did not drop to standby");
  chk_leave_clears_cur: assert property ($past(op_mode) == 2'h2 && op_mode == 2'h1 |-> coil_current_setting == 10'h000)
    else $error("current kept on leaving active mode");
  chk_entry_clears_flags: assert property ($past(op_mode) != 2'h2 && op_mode == 2'h2 |-> fault_status == 3'h0)
    else $error("status not cleared on entering active mode");
  chk_soft_rst_defaults: assert property (soft_rst_s |=> op_mode == 2'h1 && resonance_frequency_code == 8'h83 && ring_comp_enable)
    else $error("soft reset did not restore standby defaults");
  chk_low_shuts_down: assert property (low_cnt_r >= SCL_LOW_CYC + 4 |-> op_mode == 2'h0)
    else $error("long low clock line did not shut down");
  chk_shutdown_holds: assert property (op_mode == 2'h0 && !scl_pin && !$past(scl_pin) && !$past(scl_pin, 2) |=> op_mode == 2'h0)
    else $error("left shutdown while clock line low");
  chk_wake_to_standby: assert property ($rose(scl_pin) && op_mode == 2'h0 |-> ##[1:6] op_mode == 2'h1)
    else $error("no standby after clock line rise");
  chk_freq_in_range: assert property (op_mode != 2'h0 && $stable(resonance_frequency_code) |-> resonance_hz >= 8'h32 && resonance_hz <= 8'h96)
    else $error("resonance frequency out of range");
endmodule : vmc_mode_monitor
bind vmc_mode_controller vmc_mode_monitor #(.SCL_LOW_CYC(SCL_LOW_CYC)) vmc_mode_monitor_inst (
  .clk(clk), .arst_n(arst_n), .scl_pin(scl_pin), .over_temp_fault(over_temp_fault),
  .coil_short_fault(coil_short_fault), .coil_open_fault(coil_open_fault),
  .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .op_mode(op_mode),
  .drive_enable(drive_enable), .coil_current_setting(coil_current_setting),
  .resonance_frequency_code(resonance_frequency_code), .resonance_hz(resonance_hz),
  .ring_comp_enable(ring_comp_enable), .fault_status(fault_status));

// ===== core/vmc_freq_map.sv
// Maps the resonance frequency code onto the resonance frequency in hertz.
`timescale 1ns/10ps
module vmc_freq_map (
  input  wire logic [7:0] freq_code,
  output logic      [7:0] freq_hz
);

  // Count the table steps whose lowest code is reached; the table is monotone,
  // so the count is the number of whole 1 Hz steps above the base frequency.
  function automatic logic [7:0] vmc_steps(input logic [7:0] code);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 1; i <= vmc_pkg::VMC_FREQ_STEPS; i++) begin
      if (code >= vmc_pkg::VMC_FREQ_TAB[i]) begin
        n = n + 8'h01;
      end
    end
    return n;
  endfunction : vmc_steps

  assign freq_hz = vmc_pkg::VMC_FREQ_BASE_HZ + vmc_steps(freq_code);

endmodule : vmc_freq_map

// ===== core/vmc_in_sync.sv
// Two-stage synchroniser for a group of asynchronous level inputs.
`timescale 1ns/10ps
module vmc_in_sync #(
  parameter int WIDTH = 1  // Number of independent levels.
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;  // First stage; read only by the second stage.

  // Both stages clear to low; each bit is an independent level, so no bus skew matters.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : vmc_in_sync

// ===== core/vmc_mode_controller.sv
// Operating-mode controller and register file of the coil current driver.
// Operation
// - Frequency code maps monotonically onto 50-150 Hz.
// - Clock line low 0.5 ms forces shutdown.
// - Shutdown holds while clock line stays low.
// - Clock line rising: standby, registers to defaults.
// - Register writes accepted in standby.
// - Zero coil current keeps or returns standby.
// - Soft reset in active: standby plus defaults.
// - Any fault drops active to standby.
// - Fault entry to standby clears coil current.
// - Nonzero coil current written means active mode.
// - Output stage enabled throughout active mode.
// - Re-entering active after fault clears status.
// - Standby with defaults within 100 us.
// - Soft reset bit clears itself.
`timescale 1ns/10ps
module vmc_mode_controller #(
  parameter int SCL_LOW_CYC = vmc_pkg::VMC_SCL_LOW_CYC  // Low time before shutdown.
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       scl_pin,
  input  wire logic       over_temp_fault,
  input  wire logic       coil_short_fault,
  input  wire logic       coil_open_fault,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wr_data,
  output logic      [7:0] reg_rd_data,
  output logic      [1:0] op_mode,
  output logic            drive_enable,
  output logic      [9:0] coil_current_setting,
  output logic      [7:0] resonance_frequency_code,
  output logic      [7:0] resonance_hz,
  output logic            ring_comp_enable,
  output logic            pwm_mode,
  output logic      [2:0] fault_status
);

  localparam int CNT_W = $clog2(SCL_LOW_CYC + 1);  // Width of the low-time counter.

  // Synchronised pin-level inputs.
  logic       scl_s;        // Clock line level in the core domain.
  logic       scl_d_r;      // Clock line level one cycle earlier.
  logic [2:0] fault_s;      // Synchronised fault levels.

  // Mode machine and registers.
  vmc_pkg::vmc_mode_type mode_r;    // Present operating mode.
  vmc_pkg::vmc_mode_type mode_nxt;  // Next operating mode.
  logic [CNT_W-1:0]      low_cnt_r;        // Cycles the clock line has been low.
  logic [CNT_W-1:0]      low_cnt_nxt;      // Next low-time count.
  logic [7:0]            ctl_r;            // Stored control bits.
  logic [7:0]            cur_msb_r;        // Upper coil current bits.
  logic [7:0]            cur_lsb_r;        // Lower coil current bits.
  logic [7:0]            mode_reg_r;       // Stored mode register.
  logic [7:0]            freq_r;           // Resonance frequency code.
  logic [2:0]            status_r;         // Sticky fault flags.
  logic                  fault_seen_r;     // A fault took the driver out of active.
  logic [7:0]            hz_w;             // Frequency from the lookup.

  // Decoded conditions.
  wire scl_low_long = (low_cnt_r == CNT_W'(SCL_LOW_CYC));  // Low long enough.
  wire scl_rise     = scl_s & ~scl_d_r;                    // Rising clock line.
  wire any_fault    = |fault_s;                            // Any protection fault.
  wire wr_ok        = reg_wr_en & (mode_r != vmc_pkg::VMC_SHUTDOWN);
  wire wr_ctl       = wr_ok & (reg_addr == vmc_pkg::VMC_ADDR_CONTROL);
  wire wr_msb       = wr_ok & (reg_addr == vmc_pkg::VMC_ADDR_CUR_MSB);
  wire wr_lsb       = wr_ok & (reg_addr == vmc_pkg::VMC_ADDR_CUR_LSB);
  wire wr_mode      = wr_ok & (reg_addr == vmc_pkg::VMC_ADDR_MODE);
  wire wr_freq      = wr_ok & (reg_addr == vmc_pkg::VMC_ADDR_FREQ);
  wire soft_rst     = wr_ctl & reg_wr_data[vmc_pkg::VMC_CTL_SOFT_RST];
  // Current as it will stand after this edge, so that a zero write leaves
  // active in the same cycle and the mode never shows active with no current.
  wire cur_zero_nxt = ((wr_msb ? reg_wr_data : cur_msb_r) == 8'h00) &
                      (((wr_lsb ? reg_wr_data : cur_lsb_r) & vmc_pkg::VMC_CUR_LSB_MASK) == 8'h00);
  wire go_shutdown  = scl_low_long & ~scl_s;
  wire fault_trip   = (mode_r == vmc_pkg::VMC_ACTIVE) & any_fault;
  wire load_dflt    = (mode_r == vmc_pkg::VMC_SHUTDOWN) & (mode_nxt == vmc_pkg::VMC_STANDBY);
  wire do_dflt      = load_dflt | soft_rst;
  wire enter_active = (mode_r != vmc_pkg::VMC_ACTIVE) & (mode_nxt == vmc_pkg::VMC_ACTIVE);

  // Register read multiplexer; unused addresses read as zero.
  wire [7:0] rd_mux =
    (reg_addr == vmc_pkg::VMC_ADDR_CONTROL) ? ctl_r :
    (reg_addr == vmc_pkg::VMC_ADDR_CUR_MSB) ? cur_msb_r :
    (reg_addr == vmc_pkg::VMC_ADDR_CUR_LSB) ? cur_lsb_r :
    (reg_addr == vmc_pkg::VMC_ADDR_STATUS)  ? {5'h00, status_r} :
    (reg_addr == vmc_pkg::VMC_ADDR_MODE)    ? mode_reg_r :
    (reg_addr == vmc_pkg::VMC_ADDR_FREQ)    ? freq_r : 8'h00;

  // The clock line and the fault pins arrive from outside the core domain.
  vmc_in_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in ({scl_pin, coil_open_fault, coil_short_fault, over_temp_fault}),
    .sync_out ({scl_s, fault_s})
  );

  // Frequency lookup from the stored code.
  vmc_freq_map u_map (
    .freq_code (freq_r),
    .freq_hz   (hz_w)
  );

  // Low-time counter saturates so a long low keeps shutdown asserted.
  always_comb begin
    if (scl_s) begin
      low_cnt_nxt = '0;
    end else if (scl_low_long) begin
      low_cnt_nxt = low_cnt_r;
    end else begin
      low_cnt_nxt = low_cnt_r + CNT_W'(1);
    end
  end

  // Mode transitions; the clock-line shutdown outranks every other cause.
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      vmc_pkg::VMC_SHUTDOWN: begin
        // Stay while the line is low; leave on its rise, one cycle later.
        if (scl_rise) begin
          mode_nxt = vmc_pkg::VMC_STANDBY;
        end
      end
      vmc_pkg::VMC_STANDBY: begin
        if (go_shutdown) begin
          mode_nxt = vmc_pkg::VMC_SHUTDOWN;
        end else if (!cur_zero_nxt && !soft_rst) begin
          mode_nxt = vmc_pkg::VMC_ACTIVE;
        end
      end
      vmc_pkg::VMC_ACTIVE: begin
        if (go_shutdown) begin
          mode_nxt = vmc_pkg::VMC_SHUTDOWN;
        end else if (soft_rst || any_fault || cur_zero_nxt) begin
          mode_nxt = vmc_pkg::VMC_STANDBY;
        end
      end
      default: begin
        mode_nxt = vmc_pkg::VMC_SHUTDOWN;
      end
    endcase
  end

  // Mode, low-time counter and the clock-line history.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r    <= vmc_pkg::VMC_SHUTDOWN;
      low_cnt_r <= '0;
      scl_d_r   <= 1'b0;
    end else begin
      mode_r    <= mode_nxt;
      low_cnt_r <= low_cnt_nxt;
      scl_d_r   <= scl_s;
    end
  end

  // Control, mode and frequency registers; the soft reset bit is never stored.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_r      <= vmc_pkg::VMC_RST_CONTROL;
      mode_reg_r <= vmc_pkg::VMC_RST_MODE;
      freq_r     <= vmc_pkg::VMC_RST_FREQ;
    end else if (do_dflt) begin
      ctl_r      <= vmc_pkg::VMC_RST_CONTROL;
      mode_reg_r <= vmc_pkg::VMC_RST_MODE;
      freq_r     <= vmc_pkg::VMC_RST_FREQ;
    end else begin
      if (wr_ctl) begin
        ctl_r <= reg_wr_data & vmc_pkg::VMC_CTL_RW_MASK;
      end
      if (wr_mode) begin
        mode_reg_r <= reg_wr_data & vmc_pkg::VMC_MODE_RW_MASK;
      end
      if (wr_freq) begin
        freq_r <= reg_wr_data;
      end
    end
  end

  // Coil current; a fault trip clears it, and a write in the same cycle loses.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_msb_r <= vmc_pkg::VMC_RST_CUR;
      cur_lsb_r <= vmc_pkg::VMC_RST_CUR;
    end else if (do_dflt || fault_trip) begin
      cur_msb_r <= vmc_pkg::VMC_RST_CUR;
      cur_lsb_r <= vmc_pkg::VMC_RST_CUR;
    end else begin
      if (wr_msb) begin
        cur_msb_r <= reg_wr_data;
      end
      if (wr_lsb) begin
        cur_lsb_r <= reg_wr_data & vmc_pkg::VMC_CUR_LSB_MASK;
      end
    end
  end

  // Sticky fault flags: a new fault always wins over the automatic clear.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_r     <= vmc_pkg::VMC_RST_STATUS[2:0];
      fault_seen_r <= 1'b0;
    end else begin
      if (fault_trip) begin
        status_r     <= status_r | fault_s;
        fault_seen_r <= 1'b1;
      end else if (load_dflt || (enter_active && fault_seen_r)) begin
        status_r     <= vmc_pkg::VMC_RST_STATUS[2:0];
        fault_seen_r <= 1'b0;
      end
    end
  end

  // Registered outputs; the output stage follows the next mode so that it is
  // on in exactly the cycles in which the mode output shows active.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_enable <= 1'b0;
      op_mode      <= 2'h0;
      reg_rd_data  <= 8'h00;
      resonance_hz <= 8'h00;
    end else begin
      drive_enable <= (mode_nxt == vmc_pkg::VMC_ACTIVE);
      op_mode      <= mode_nxt;
      reg_rd_data  <= rd_mux;
      resonance_hz <= hz_w;
    end
  end

  // Plain register views are already flip-flop outputs.
  assign coil_current_setting     = {cur_msb_r, cur_lsb_r[vmc_pkg::VMC_CUR_LSB_W-1:0]};
  assign resonance_frequency_code = freq_r;
  assign ring_comp_enable         = ctl_r[vmc_pkg::VMC_CTL_RING_EN];
  assign pwm_mode                 = mode_reg_r[vmc_pkg::VMC_MODE_PWM];
  assign fault_status             = status_r;

endmodule : vmc_mode_controller

// ===== core/vmc_pkg.sv
// Shared constants, register map and types for the coil driver mode controller.
package vmc_pkg;

  // Register indices on the serial register port.
  localparam logic [7:0] VMC_ADDR_CONTROL = 8'h02;  // Control register.
  localparam logic [7:0] VMC_ADDR_CUR_MSB = 8'h03;  // Coil current, upper bits.
  localparam logic [7:0] VMC_ADDR_CUR_LSB = 8'h04;  // Coil current, lower bits.
  localparam logic [7:0] VMC_ADDR_STATUS  = 8'h05;  // Status register, read only.
  localparam logic [7:0] VMC_ADDR_MODE    = 8'h06;  // Mode register.
  localparam logic [7:0] VMC_ADDR_FREQ    = 8'h07;  // Resonance frequency code.

  // Reset values of the registers.
  localparam logic [7:0] VMC_RST_CONTROL = 8'h02;  // Ringing compensation on by default.
  localparam logic [7:0] VMC_RST_CUR     = 8'h00;  // No coil current.
  localparam logic [7:0] VMC_RST_STATUS  = 8'h00;  // No faults.
  localparam logic [7:0] VMC_RST_MODE    = 8'h00;  // Linear output stage.
  localparam logic [7:0] VMC_RST_FREQ    = 8'h83;  // Resonance frequency code default.

  // Field positions.
  localparam int VMC_CTL_SOFT_RST = 0;  // Soft reset bit in the control register.
  localparam int VMC_CTL_RING_EN  = 1;  // Ringing compensation enable.
  localparam int VMC_MODE_PWM     = 0;  // Output stage in switching mode when set.
  localparam int VMC_ST_OVERTEMP  = 0;  // Status: over-temperature fault.
  localparam int VMC_ST_SHORT     = 1;  // Status: coil short fault.
  localparam int VMC_ST_OPEN      = 2;  // Status: coil open fault.
  localparam int VMC_CUR_LSB_W    = 2;  // Current bits held in the lower register.
  localparam logic [7:0] VMC_CTL_RW_MASK = 8'h02;  // Only the enable bit is stored.
  localparam logic [7:0] VMC_MODE_RW_MASK = 8'h01;  // Only the mode bit is stored.
  localparam logic [7:0] VMC_CUR_LSB_MASK = 8'h03;  // Lower current bits.

  // Timing figures and their cycle counts at the 10 MHz core clock.
  localparam int VMC_CLK_HZ        = 10000000;  // Core clock rate.
  localparam int VMC_SCL_LOW_NS    = 500000;    // Clock-line low time to shut down.
  localparam int VMC_SCL_LOW_CYC   = (VMC_SCL_LOW_NS / 100) * (VMC_CLK_HZ / 10000000);
  localparam int VMC_WAKE_MAX_NS   = 100000;    // Longest wake time to standby.
  localparam int VMC_WAKE_MAX_CYC  = (VMC_WAKE_MAX_NS / 100) * (VMC_CLK_HZ / 10000000);

  // Frequency map: lowest code for each 1 Hz step from the base frequency upward.
  localparam logic [7:0] VMC_FREQ_BASE_HZ = 8'h32;  // Frequency of code zero.
  localparam int         VMC_FREQ_STEPS   = 100;    // Steps up to the top frequency.
  localparam logic [7:0] VMC_FREQ_TAB [0:100] = '{
    8'h00, 8'h07, 8'h0E, 8'h15, 8'h1B, 8'h22, 8'h28, 8'h2E, 8'h34, 8'h3A, 8'h3F,
    8'h44, 8'h49, 8'h4E, 8'h53, 8'h58, 8'h5C, 8'h60, 8'h65, 8'h69, 8'h6D, 8'h71,
    8'h74, 8'h78, 8'h7C, 8'h7F, 8'h82, 8'h86, 8'h89, 8'h8C, 8'h8F, 8'h92, 8'h95,
    8'h98, 8'h9A, 8'h9D, 8'hA0, 8'hA2, 8'hA5, 8'hA7, 8'hAA, 8'hAC, 8'hAE, 8'hB1,
    8'hB3, 8'hB5, 8'hB7, 8'hB9, 8'hBB, 8'hBD, 8'hBF, 8'hC1, 8'hC3, 8'hC5, 8'hC6,
    8'hC8, 8'hCA, 8'hCC, 8'hCD, 8'hCF, 8'hD0, 8'hD2, 8'hD4, 8'hD5, 8'hD7, 8'hD8,
    8'hD9, 8'hDB, 8'hDC, 8'hDE, 8'hDF, 8'hE0, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE7,
    8'hE8, 8'hE9, 8'hEA, 8'hEB, 8'hEC, 8'hEE, 8'hEF, 8'hF0, 8'hF1, 8'hF2, 8'hF3,
    8'hF4, 8'hF5, 8'hF6, 8'hF7, 8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFB, 8'hFC, 8'hFD,
    8'hFE, 8'hFF
  };

  // Operating modes of the driver.
  typedef enum logic [1:0] {
    VMC_SHUTDOWN,
    VMC_STANDBY,
    VMC_ACTIVE
  } vmc_mode_type;

endpackage : vmc_pkg
